// File: design/sfp_ctrl.sv
// Purpose: Standby, deep power-down and pause control for a serial flash front end
// Assumes: CLK far faster than SCK; pins are asynchronous and synchronised here
// Notes:   The memory core sits behind the user-side ports
// Summary of operation
// - Standby whenever chip select is high, no self-timed operation runs and deep power-down is neither entered, held nor left.
// - In deep power-down every command except resume is ignored.
// - Opcode B9h then chip select high enters deep power-down.
// - Bits after the eight opcode bits of both power commands are discarded.
// - Chip select high before a full entry opcode aborts; standby kept.
// - Reset leaves the device in standby, never deep power-down.
// - Entry opcode ignored while a program or erase runs.
// - Opcode ABh then chip select high returns to standby.
// - Incomplete resume opcode aborts; device stays in deep power-down.
// - Pause never suspends a running program or erase.
// - Pause starts with chip select low, pause pin low, clock low.
// - Pause holds while pause pin and chip select stay asserted.
// - While paused output floats; data input and clock ignored.
// - Write-protect input keeps working while paused.
// - Pause ends when pause pin rises, at a clock low phase.
// - Chip select high while paused aborts pause and the operation.
// - Aborted guarded operation from pause abort clears the write enable latch.
// - Deep power-down reached within 3 us after chip select rises.
// - Standby reached within 3 us after chip select rises on resume.
// - Guarded commands rejected while the write enable latch is 0.
`timescale 1ns/10ps
`default_nettype none
module sfp_ctrl (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic        SI,
  input  wire logic        HOLD_N,
  input  wire logic        WP_N,
  output logic             SO,
  output logic             SO_OE,
  input  wire logic        BUSY,
  input  wire logic        SO_BIT,
  input  wire logic        SO_EN,
  input  wire logic        LATCH_SET,
  input  wire logic        LATCH_CLR,
  input  wire logic        OP_GUARDED,
  output logic [7:0]       OP_CODE,
  output logic             OP_VALID,
  output logic             OP_REJECT,
  output logic [7:0]       RX_BYTE,
  output logic             RX_VALID,
  output logic             FRAME_END,
  output logic             FRAME_ABORT,
  output logic             WRITE_ENABLE_LATCH,
  output logic             WP_ACTIVE,
  output logic             STANDBY,
  output logic             DEEP_PD,
  output logic             PAUSED
);
  import sfp_pkg::*;
  localparam int ENTRY_MAX = PD_ENTRY_CYC;
  localparam int EXIT_MAX  = PD_EXIT_CYC;

  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              cs_act;
  logic              sck_s, si_s;
  logic              hold_act;
  logic              cs_act_q, sck_q;
  logic              cs_fall, cs_rise, sck_rise;

  sfp_sync #(
    .W       (SYNC_W),
    .RST_VAL (PIN_SYNC_RST)
  ) u_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  ({CS_N, SCK, SI, HOLD_N, WP_N}),
    .dout (pins_s)
  );

  assign cs_act   = ~pins_s[4];
  assign sck_s    = pins_s[3];
  assign si_s     = pins_s[2];
  assign hold_act = ~pins_s[1];

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cs_act_q <= 1'b0;
      sck_q    <= 1'b1; // Matches synchroniser reset, no false edge
    end
    else
    begin
      cs_act_q <= cs_act;
      sck_q    <= sck_s;
    end
  end

  assign cs_fall  = cs_act & ~cs_act_q;
  assign cs_rise  = ~cs_act & cs_act_q;
  assign sck_rise = sck_s & ~sck_q;

  // Write protect is not gated by pause
  assign WP_ACTIVE = ~pins_s[0];

  // ---------------------------------------------------------------
  // Pause mode
  // ---------------------------------------------------------------
  logic paused_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      paused_q <= 1'b0;
    else if (!cs_act)
      paused_q <= 1'b0;
    else if (!paused_q && hold_act && !sck_s)
      paused_q <= 1'b1;
    else if (paused_q && !hold_act && !sck_s)
      paused_q <= 1'b0;
  end

  assign PAUSED = paused_q;

  // ---------------------------------------------------------------
  // Bit shifter, MSB first on rising clock
  // ---------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] shreg_q;
  logic [7:0] byte_q;
  logic       byte_new_q, opc_done_q;
  logic [7:0] opc_q;
  logic       sck_take;

  // Clock edges while paused never reach the shifter
  assign sck_take = sck_rise & cs_act & ~paused_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      bit_cnt_q  <= 3'h0;
      shreg_q    <= 7'h00;
      byte_q     <= 8'h00;
      byte_new_q <= 1'b0;
    end
    else
    begin
      byte_new_q <= 1'b0;
      if (cs_fall)
        bit_cnt_q <= 3'h0;
      else if (sck_take)
      begin
        shreg_q   <= {shreg_q[5:0], si_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          byte_q     <= {shreg_q, si_s};
          byte_new_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      opc_done_q <= 1'b0;
      opc_q      <= 8'h00;
    end
    else if (cs_fall)
      opc_done_q <= 1'b0;
    else if (byte_new_q && !opc_done_q)
    begin
      opc_done_q <= 1'b1;
      opc_q      <= byte_q;
    end
  end

  // Opcode may complete in the same cycle that chip select rise is seen
  logic       opc_full;
  logic [7:0] opc_now;
  logic       is_pwr_cmd;

  assign opc_full   = opc_done_q | byte_new_q;
  assign opc_now    = opc_done_q ? opc_q : byte_q;
  assign is_pwr_cmd = (opc_q == OPC_PD_ENTER) || (opc_q == OPC_PD_RESUME);

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  sfp_pwr_t          pw_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              enter_go, exit_go;

  assign enter_go = (pw_q == PW_NORMAL) && cs_rise && !paused_q && opc_full
                    && (opc_now == OPC_PD_ENTER) && !BUSY;
  assign exit_go  = (pw_q == PW_DEEP) && cs_rise && !paused_q && opc_full
                    && (opc_now == OPC_PD_RESUME);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pw_q  <= PW_NORMAL;
      tmr_q <= '0;
    end
    else
    begin
      case (pw_q)
        PW_NORMAL:
        begin
          tmr_q <= '0;
          if (enter_go)
            pw_q <= PW_ENTER;
        end
        PW_ENTER:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == PD_ENTRY_SETTLE)
            pw_q <= PW_DEEP;
        end
        PW_DEEP:
        begin
          tmr_q <= '0;
          if (exit_go)
            pw_q <= PW_EXIT;
        end
        PW_EXIT:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == PD_EXIT_SETTLE)
            pw_q <= PW_NORMAL;
        end
        default:
          pw_q <= PW_NORMAL;
      endcase
    end
  end

  assign DEEP_PD = (pw_q == PW_DEEP);
  // Self-timed work keeps the part out of standby, pause or not
  assign STANDBY = (pw_q == PW_NORMAL) && !cs_act && !BUSY;

  // ---------------------------------------------------------------
  // Command forwarding to the core
  // ---------------------------------------------------------------
  logic awake, op_new, reject;
  logic frame_dead_q, guard_live_q;

  assign awake  = (pw_q == PW_NORMAL);
  assign op_new = byte_new_q & ~opc_done_q & awake;
  assign reject = op_new & OP_GUARDED & ~WRITE_ENABLE_LATCH;

  assign OP_CODE   = byte_q;
  assign OP_VALID  = op_new & ~reject;
  assign OP_REJECT = reject;
  assign RX_BYTE   = byte_q;
  // Trailing bytes of the power commands go nowhere
  assign RX_VALID  = byte_new_q & opc_done_q & awake & ~is_pwr_cmd & ~frame_dead_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      frame_dead_q <= 1'b0;
      guard_live_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      frame_dead_q <= 1'b0;
      guard_live_q <= 1'b0;
    end
    else if (op_new)
    begin
      frame_dead_q <= reject;
      guard_live_q <= OP_GUARDED & ~reject;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      FRAME_END   <= 1'b0;
      FRAME_ABORT <= 1'b0;
    end
    else
    begin
      FRAME_END   <= cs_rise & ~paused_q & awake;
      FRAME_ABORT <= cs_rise & paused_q & awake;
    end
  end

  // ---------------------------------------------------------------
  // Write enable latch
  // ---------------------------------------------------------------
  logic latch_q, latch_abort;

  // Only a fully received guarded opcode clears the latch on abort
  assign latch_abort = cs_rise & paused_q & guard_live_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      latch_q <= LATCH_RST;
    else if (LATCH_SET)
      latch_q <= 1'b1;
    else if (LATCH_CLR || latch_abort)
      latch_q <= 1'b0;
  end

  assign WRITE_ENABLE_LATCH = latch_q;

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      SO    <= 1'b0;
      SO_OE <= 1'b0;
    end
    else
    begin
      SO    <= SO_BIT;
      SO_OE <= SO_EN & cs_act & ~paused_q & awake;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_deep_ignores: assert property (@(posedge CLK) disable iff (RST)
    (pw_q != PW_NORMAL) |-> !OP_VALID && !RX_VALID)
    else $error("command passed while powered down");
  a_entry_bound: assert property (@(posedge CLK) disable iff (RST)
    enter_go |-> ##[1:ENTRY_MAX] (pw_q == PW_DEEP))
    else $error("deep power-down not reached in time");
  a_short_entry: assert property (@(posedge CLK) disable iff (RST)
    ((pw_q == PW_NORMAL) && cs_rise && !opc_full) |=> (pw_q == PW_NORMAL))
    else $error("incomplete entry opcode left standby");
  a_busy_blocks: assert property (@(posedge CLK) disable iff (RST)
    ((pw_q == PW_NORMAL) && BUSY) |=> (pw_q != PW_ENTER))
    else $error("entry taken during self-timed operation");
  a_exit_bound: assert property (@(posedge CLK) disable iff (RST)
    exit_go |-> ##[1:EXIT_MAX] (pw_q == PW_NORMAL))
    else $error("standby not reached in time");
  a_resume_abort: assert property (@(posedge CLK) disable iff (RST)
    ((pw_q == PW_DEEP) && cs_rise && !opc_full) |=> (pw_q == PW_DEEP))
    else $error("incomplete resume left deep power-down");
  a_pause_float: assert property (@(posedge CLK) disable iff (RST)
    paused_q |=> !SO_OE)
    else $error("output driven while paused");
  a_pause_start: assert property (@(posedge CLK) disable iff (RST)
    (cs_act && hold_act && !sck_s && !paused_q) |=> paused_q)
    else $error("pause not entered in low phase");
  a_abort_latch: assert property (@(posedge CLK) disable iff (RST)
    (latch_abort && !LATCH_SET) |=> !latch_q)
    else $error("latch kept after pause abort");
  a_guard_reject: assert property (@(posedge CLK) disable iff (RST)
    (op_new && OP_GUARDED && !latch_q) |-> OP_REJECT && !OP_VALID)
    else $error("guarded opcode accepted without latch");

endmodule
`default_nettype wire

// File: design/sfp_pkg.sv
// Purpose: Shared constants and types for the serial flash power and pause control block
// Assumes: Core clock of 10 MHz, serial pins sampled by that clock
// Notes:   Timing counts follow from the time limits and the clock period
package sfp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 100;
  localparam int POWER_DOWN_ENTRY_TIME_US = 3;
  localparam int POWER_DOWN_EXIT_TIME_US  = 3;
  // Longest times round down to whole cycles
  localparam int PD_ENTRY_CYC = (POWER_DOWN_ENTRY_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int PD_EXIT_CYC  = (POWER_DOWN_EXIT_TIME_US * 1000) / CLK_PERIOD_NS;
  // Settle well inside the limit, leaving room for pin sampling delay
  localparam int TMR_W = 6;
  localparam logic [TMR_W-1:0] PD_ENTRY_SETTLE = TMR_W'(PD_ENTRY_CYC / 2);
  localparam logic [TMR_W-1:0] PD_EXIT_SETTLE  = TMR_W'(PD_EXIT_CYC / 2);

  // ---------------------------------------------------------------
  // Opcodes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_PD_ENTER  = 8'hB9;
  localparam logic [7:0] OPC_PD_RESUME = 8'hAB;
  localparam logic       LATCH_RST     = 1'b0;
  localparam int         SYNC_W        = 5;
  // CS_N, SCK, HOLD_N and WP_N idle high, SI low
  localparam logic [SYNC_W-1:0] PIN_SYNC_RST = 5'h1B;

  typedef enum logic [1:0] {
    PW_NORMAL = 2'h0,
    PW_ENTER  = 2'h1,
    PW_DEEP   = 2'h2,
    PW_EXIT   = 2'h3
  } sfp_pwr_t;

endpackage

// File: design/sfp_sync.sv
// Purpose: Two-stage synchroniser for a group of independent pin levels
// Assumes: Each bit is an unrelated level; no bus coherency needed
// Notes:   Stage one feeds only stage two
`timescale 1ns/10ps
`default_nettype none
module sfp_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [W-1:0]   din,
  output logic      [W-1:0]   dout
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
        end
        else
        begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate

endmodule
`default_nettype wire

// File: verif/sfp_host.sv
// Purpose: Host serial bus master driving the power and pause block
// Assumes: Mode 0, SCK of 800 ns, every pin moved on a CLK rise
// Notes:   SI is flipped between frames so a stale bit never lingers
`timescale 1ns/10ps
`default_nettype none
module sfp_host (
  input  wire logic clk,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic hold_n
);
  initial
  begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Sends bits[15 -: n]; pause in the high phase of bit hold_at
  task automatic xfer(input logic [15:0] bits, input int n, input int hold_at, input bit abort);
    @(posedge clk);
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      si <= bits[15-i];
      tick(4);
      sck <= 1'b1;
      tick(2);
      if (i == hold_at)
        hold_n <= 1'b0;
      tick(2);
      sck <= 1'b0;
      if (i == hold_at)
      begin
        // Clock and data keep moving while paused
        repeat (2)
        begin
          tick(4);
          si  <= ~si;
          sck <= 1'b1;
          tick(4);
          sck <= 1'b0;
        end
        tick(4);
        if (abort)
        begin
          cs_n <= 1'b1;
          tick(6);
          hold_n <= 1'b1;
          tick(6);
          si <= ~si;
          return;
        end
        hold_n <= 1'b1;
        tick(4);
      end
    end
    tick(4);
    cs_n <= 1'b1;
    tick(8);
    si <= ~si;
  endtask
endmodule
`default_nettype wire

// File: verif/test_sfp_ctrl.sv
// Purpose: Self-checking bench for the power and pause block
// Assumes: Core side played by the bench; guarded opcode is arbitrary
// Notes:   Pulse outputs are counted on every rising clock edge
`timescale 1ns/10ps
`default_nettype none
module test_sfp_ctrl;
  import sfp_pkg::*;
  localparam logic [7:0] OPC_GUARD = 8'h02;
  // Generous: all frames together need about 1250 cycles
  localparam int WATCHDOG_CYC = 20000;
  logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, busy = 1'b0, so_bit = 1'b0, so_en = 1'b0;
  logic latch_set = 1'b0, latch_clr = 1'b0, op_guarded, cs_n, sck, si, hold_n;
  logic so, so_oe, op_valid, op_reject, rx_valid, frame_end, frame_abort;
  logic latch, wp_active, standby, deep_pd, paused;
  logic [7:0] op_code, rx_byte, last_op;
  int mismatches = 0, checked = 0, n_opv, n_rej, n_rx, n_end, n_abt;

  always #50 clk = ~clk;
  assign op_guarded = (op_code === OPC_GUARD);

  sfp_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  sfp_ctrl u_dut (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n),
    .SO(so), .SO_OE(so_oe), .BUSY(busy), .SO_BIT(so_bit), .SO_EN(so_en),
    .LATCH_SET(latch_set), .LATCH_CLR(latch_clr), .OP_GUARDED(op_guarded), .OP_CODE(op_code),
    .OP_VALID(op_valid), .OP_REJECT(op_reject), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
    .FRAME_END(frame_end), .FRAME_ABORT(frame_abort), .WRITE_ENABLE_LATCH(latch),
    .WP_ACTIVE(wp_active),
    .STANDBY(standby), .DEEP_PD(deep_pd), .PAUSED(paused)
  );

  always @(posedge clk)
  begin
    n_opv += (op_valid === 1'b1);
    n_rej += (op_reject === 1'b1);
    n_rx  += (rx_valid === 1'b1);
    n_end += (frame_end === 1'b1);
    n_abt += (frame_abort === 1'b1);
    // Opcode register is overwritten by later bytes
    if (op_valid === 1'b1)
      last_op = op_code;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic fail(input string what);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic chkn(input int got, input int exp, input string what);
    checked++;
    if (got != exp)
      fail(what);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++)
      @(posedge clk);
    @(negedge clk);
  endtask
  task automatic clr();
    @(negedge clk);
    {n_opv, n_rej, n_rx, n_end, n_abt} = '0;
    last_op = 8'h00;
  endtask
  task automatic pulse_latch(input bit set);
    @(posedge clk);
    if (set)
      latch_set <= 1'b1;
    else
      latch_clr <= 1'b1;
    @(posedge clk);
    latch_set <= 1'b0;
    latch_clr <= 1'b0;
    settle(1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    settle(0);
    chk1(standby, 1'b1, "standby after reset");
    chk1(deep_pd, 1'b0, "deep after reset");
    clr();
    u_host.xfer({OPC_PD_ENTER, 8'h00}, 7, -1, 1'b0);
    settle(30);
    chk1(deep_pd, 1'b0, "short entry");
    chk1(standby, 1'b1, "standby after short entry");
    @(posedge clk);
    busy <= 1'b1;
    u_host.xfer({OPC_PD_ENTER, 8'h00}, 8, -1, 1'b0);
    chk1(standby, 1'b0, "standby while busy");
    @(posedge clk);
    busy <= 1'b0;
    settle(30);
    chk1(deep_pd, 1'b0, "entry while busy");
    clr();
    u_host.xfer({OPC_PD_ENTER, 8'h5A}, 16, -1, 1'b0);
    chk8(last_op, OPC_PD_ENTER, "entry opcode");
    chkn(n_rx, 0, "bytes after entry");
    wait_for(deep_pd, 1'b1, 22);
    chk1(deep_pd, 1'b1, "entry time");
    $display("test power entry done");
  endtask

  task automatic t_resume();
    clr();
    @(posedge clk);
    so_en <= 1'b1;
    u_host.xfer({8'h05, 8'h00}, 16, -1, 1'b0);
    chkn(n_opv, 0, "command in deep");
    chk1(so_oe, 1'b0, "output in deep");
    u_host.xfer({OPC_PD_RESUME, 8'h00}, 7, -1, 1'b0);
    settle(30);
    chk1(deep_pd, 1'b1, "short resume");
    u_host.xfer({OPC_PD_RESUME, 8'hFF}, 16, -1, 1'b0);
    wait_for(standby, 1'b1, 22);
    chk1(standby, 1'b1, "resume time");
    chk1(deep_pd, 1'b0, "deep after resume");
    chkn(n_opv + n_rx, 0, "bytes after resume");
    @(posedge clk);
    so_en <= 1'b0;
    $display("test resume done");
  endtask

  task automatic t_guard();
    clr();
    u_host.xfer({OPC_GUARD, 8'h33}, 16, -1, 1'b0);
    chkn(n_rej, 1, "reject count");
    chkn(n_rx, 0, "data after reject");
    pulse_latch(1'b1);
    pulse_latch(1'b0);
    chk1(latch, 1'b0, "latch clear");
    pulse_latch(1'b1);
    chk1(latch, 1'b1, "latch set");
    $display("test guard done");
  endtask

  task automatic t_pause();
    clr();
    @(posedge clk);
    so_en  <= 1'b1;
    so_bit <= 1'b1;
    fork
      u_host.xfer({OPC_GUARD, 8'hC3}, 16, 10, 1'b0);
      begin
        wait_for(paused, 1'b1, 150);
        chk1(paused, 1'b1, "pause start");
        settle(2);
        chk1(so_oe, 1'b0, "output floats");
        @(posedge clk);
        wp_n <= 1'b0;
        settle(3);
        chk1(wp_active, 1'b1, "protect in pause");
        @(posedge clk);
        wp_n <= 1'b1;
        settle(3);
        chk1(wp_active, 1'b0, "protect off in pause");
        chk1(paused, 1'b1, "pause holds");
        wait_for(paused, 1'b0, 40);
        chk1(paused, 1'b0, "pause end");
        chk1(so_oe, 1'b1, "output back after pause");
        chk1(so, 1'b1, "output data bit");
      end
    join
    chkn(n_opv, 1, "guarded opcode accepted");
    chkn(n_rx, 1, "one data byte");
    chk8(rx_byte, 8'hC3, "data across pause");
    chkn(n_end, 1, "frame end");
    so_en <= 1'b0;
    clr();
    u_host.xfer({OPC_GUARD, 8'h00}, 12, 9, 1'b1);
    settle(4);
    chkn(n_abt, 1, "pause abort");
    chkn(n_end, 0, "no normal end");
    chk1(paused, 1'b0, "pause gone");
    chk1(latch, 1'b0, "latch cleared");
    $display("test pause done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(4);
    t_power();
    t_resume();
    t_guard();
    t_pause();
    final_report();
  end

  initial
  begin
    repeat (WATCHDOG_CYC) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
